// >>> shared/sac_pkg.sv
// Purpose: Shared constants and types for the step attenuator control port
// Assumes: 50 MHz system clock
// Notes:   Attenuation codes are in quarter-decibel units
package sac_pkg;

    localparam int          ATTEN_BITS      = 7;
    localparam int          WORD_BITS       = 8;
    localparam int          SHIFT_BITS      = 16;
    localparam int          STRAP_BITS      = 3;
    localparam int          ATTEN_LSB       = 0;
    localparam int          ADDR_LSB        = 8;
    localparam int          TOP_BIT_POS     = 7;
    localparam logic [6:0]  ATTEN_MAX       = 7'h7f;
    localparam logic [6:0]  ATTEN_MIN       = 7'h00;
    localparam int          CLK_MHZ         = 50;
    localparam int          PUP_DELAY_US    = 400;
    localparam int          PUP_CYCLES      = PUP_DELAY_US * CLK_MHZ;
    localparam int          CNT_BITS        = 16;
    localparam int          SYNC_SETTLE     = 2;

    typedef enum logic [1:0] {
        SAC_PUP_HOLD = 2'b00,
        SAC_RUN      = 2'b01
    } sac_phase_t;

    typedef struct packed {
        logic                  sel_serial;
        logic                  strobe;
        logic                  sclk;
        logic                  sdata;
        logic [ATTEN_BITS-1:0] par;
        logic                  par_float;
        logic [STRAP_BITS-1:0] strap;
    } sac_pins_t;

endpackage

// >>> verilog/sac_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin inputs
// Assumes: Pins are asynchronous to clock
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module sac_sync
    import sac_pkg::*;
(
    input  wire logic      clock, // System clock
    input  wire logic      reset, // Synchronous reset, active high
    input  wire sac_pins_t pins,  // Raw pin levels
    output sac_pins_t      synced // Pins after two flip-flops
);
    typedef struct packed {
        sac_pins_t meta;
        sac_pins_t hold;
    } sac_sync_state_t;

    sac_sync_state_t state;
    sac_sync_state_t next_state;

    always_comb begin
        next_state      = state;
        next_state.meta = pins;
        next_state.hold = state.meta;
        if (reset) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clock) begin
        state <= next_state;
    end

    assign synced = state.hold;
endmodule

// >>> verilog/sac_shift.sv
// Purpose: 16-bit serial-in parallel-out shift register
// Assumes: Edge strobe comes from synchronised serial clock
// Notes:   New bits enter at the top, so the first bit ends at bit 0
`timescale 1ns/10ps
module sac_shift
    import sac_pkg::*;
(
    input  wire logic                  clock, // System clock
    input  wire logic                  reset, // Synchronous reset, active high
    input  wire logic                  shift, // One-cycle shift request
    input  wire logic                  sdata, // Serial data bit
    output logic [SHIFT_BITS-1:0]      word   // Parallel contents
);
    typedef struct packed {
        logic [SHIFT_BITS-1:0] sr;
    } sac_shift_state_t;

    sac_shift_state_t state;
    sac_shift_state_t next_state;

    always_comb begin
        next_state = state;
        if (shift) begin
            // Older bits fall off bit 0: only the last sixteen stay
            next_state.sr = {sdata, state.sr[SHIFT_BITS-1:1]};
        end
        if (reset) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clock) begin
        state <= next_state;
    end

    assign word = state.sr;
endmodule

// >>> verilog/sac_top.sv
// Purpose: Control logic of a 7-bit step attenuator, parallel and serial port
// Assumes: All pins asynchronous; reset stands for power-up
// Notes:   Serial clock is sampled and its edges found on the system clock
`timescale 1ns/10ps
module sac_top
    import sac_pkg::*;
#(
    parameter int PUP_COUNT = PUP_CYCLES // Power-up delay in cycles
)(
    input  wire logic                  clock,                   // System clock, 50 MHz
    input  wire logic                  reset,                   // Power-up reset, active high
    input  wire logic                  sel_serial,              // Low parallel, high serial
    input  wire logic                  latch_strobe,            // Latch strobe pin
    input  wire logic                  serial_clock,            // Serial shift clock pin
    input  wire logic                  serial_data,             // Serial data pin
    input  wire logic [ATTEN_BITS-1:0] parallel_control_inputs, // Parallel step bits
    input  wire logic                  parallel_float,          // Parallel pins left open
    input  wire logic                  addr_strap_bit0,         // Address strap 0
    input  wire logic                  addr_strap_bit1,         // Address strap 1
    input  wire logic                  addr_strap_bit2,         // Address strap 2
    output logic [ATTEN_BITS-1:0]      atten_state,             // Applied attenuation code
    output logic                       atten_word_top_bit,      // Held bit 7 of serial word
    output logic                       power_up_busy            // Power-up delay running
);
    typedef struct packed {
        sac_phase_t            phase;
        logic [CNT_BITS-1:0]   count;
        logic                  pup_direct;
        logic                  pup_float;
        logic                  sclk_prev;
        logic                  strobe_prev;
        logic [ATTEN_BITS-1:0] atten;
        logic                  top_bit;
        logic                  busy;
    } sac_state_t;

    sac_pins_t             pins;
    sac_pins_t             sp;
    logic [SHIFT_BITS-1:0] sr_word;
    logic                  shift_now;
    sac_state_t            state;
    sac_state_t            next_state;

    // Port behaviour decoded from the synchronised select and strobe
    typedef enum logic [1:0] {
        SAC_MODE_LATCHED = 2'b00,
        SAC_MODE_DIRECT  = 2'b01,
        SAC_MODE_SERIAL  = 2'b10
    } sac_mode_t;

    logic                  sclk_rise;
    logic                  strobe_rise;
    sac_mode_t             mode;
    logic                  serial_hit;
    logic [ATTEN_BITS-1:0] serial_code;
    logic                  serial_top;
    logic [ATTEN_BITS-1:0] pup_code;
    logic                  settle_point;
    logic                  delay_done;
    logic [CNT_BITS-1:0]   count_next;

    function automatic logic addr_match(input logic [SHIFT_BITS-1:0] w,
                                        input logic [STRAP_BITS-1:0] s);
        return w[ADDR_LSB +: STRAP_BITS] == s;
    endfunction

    // Edges are found on synchronised samples only, never on a raw pin
    function automatic logic is_rise(input logic prev,
                                     input logic now);
        return now && !prev;
    endfunction

    // Direct needs the strobe high on two samples, so the rising sample of a latch pulse is still latched
    function automatic sac_mode_t port_mode(input logic serial,
                                            input logic strobe_now,
                                            input logic strobe_prev);
        sac_mode_t pick;
        pick = SAC_MODE_LATCHED;
        if (serial) begin
            pick = SAC_MODE_SERIAL;
        end else if (strobe_now && strobe_prev) begin
            pick = SAC_MODE_DIRECT;
        end
        return pick;
    endfunction

    // Code applied when the power-up delay ends
    function automatic logic [ATTEN_BITS-1:0] preset_code(input logic direct,
                                                          input logic floating,
                                                          input logic [ATTEN_BITS-1:0] par);
        logic [ATTEN_BITS-1:0] code;
        code = ATTEN_MAX;
        if (direct) begin
            code = floating ? ATTEN_MIN : par;
        end
        return code;
    endfunction

    function automatic logic [ATTEN_BITS-1:0] word_code(input logic [SHIFT_BITS-1:0] w);
        return w[ATTEN_LSB +: ATTEN_BITS];
    endfunction

    assign pins.sel_serial = sel_serial;
    assign pins.strobe     = latch_strobe;
    assign pins.sclk       = serial_clock;
    assign pins.sdata      = serial_data;
    assign pins.par        = parallel_control_inputs;
    assign pins.par_float  = parallel_float;
    assign pins.strap      = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

    sac_sync u_sync (
        .clock  (clock),
        .reset  (reset),
        .pins   (pins),
        .synced (sp)
    );

    // Shift only on a serial clock rise while strobe low, in serial mode
    assign sclk_rise    = is_rise(state.sclk_prev, sp.sclk);
    assign strobe_rise  = is_rise(state.strobe_prev, sp.strobe);
    assign shift_now    = sp.sel_serial && !sp.strobe && sclk_rise;
    assign mode         = port_mode(sp.sel_serial, sp.strobe, state.strobe_prev);
    assign serial_hit   = strobe_rise && addr_match(sr_word, sp.strap);
    assign serial_code  = word_code(sr_word);
    assign serial_top   = sr_word[TOP_BIT_POS];
    assign pup_code     = preset_code(state.pup_direct, state.pup_float, sp.par);
    assign settle_point = state.count == CNT_BITS'(SYNC_SETTLE);
    assign delay_done   = state.count >= CNT_BITS'(PUP_COUNT) - CNT_BITS'(1);
    assign count_next   = state.count + CNT_BITS'(1);

    sac_shift u_shift (
        .clock (clock),
        .reset (reset),
        .shift (shift_now),
        .sdata (sp.sdata),
        .word  (sr_word)
    );

    always_comb begin
        next_state             = state;
        next_state.sclk_prev   = sp.sclk;
        next_state.strobe_prev = sp.strobe;
        case (state.phase)
            SAC_PUP_HOLD: begin
                // Maximum held while the power-up delay runs
                next_state.atten = ATTEN_MAX;
                next_state.busy  = 1'b1;
                // Mode caught only once the synchroniser holds real pin levels
                if (settle_point) begin
                    next_state.pup_direct = !sp.sel_serial && sp.strobe;
                    next_state.pup_float  = sp.par_float;
                end
                if (delay_done) begin
                    next_state.phase = SAC_RUN;
                    next_state.busy  = 1'b0;
                    // Latched and serial keep maximum until the host latches a word
                    next_state.atten = pup_code;
                end else begin
                    next_state.count = count_next;
                end
            end
            SAC_RUN: begin
                case (mode)
                    SAC_MODE_DIRECT: begin
                        // Strobe held high: transparent
                        next_state.atten = sp.par;
                    end
                    SAC_MODE_LATCHED: begin
                        // Capture on rise; inputs must be stable over the pulse
                        if (strobe_rise) begin
                            next_state.atten = sp.par;
                        end
                    end
                    SAC_MODE_SERIAL: begin
                        // Transfer ignores serial clock level; top bit kept
                        if (serial_hit) begin
                            next_state.atten   = serial_code;
                            next_state.top_bit = serial_top;
                        end
                    end
                    default: begin
                        next_state.atten = state.atten;
                    end
                endcase
            end
            default: begin
                next_state.phase = SAC_PUP_HOLD;
            end
        endcase
        if (reset) begin
            next_state            = '0;
            next_state.phase      = SAC_PUP_HOLD;
            next_state.atten      = ATTEN_MAX;
            next_state.busy       = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        state <= next_state;
    end

    assign atten_state        = state.atten;
    assign atten_word_top_bit = state.top_bit;
    assign power_up_busy      = state.busy;
endmodule

// >>> test/sac_top_sva.sv
// Purpose: Port-level checks of the step attenuator control port
// Assumes: Bound to sac_top; straps and serial word are judged by the bench
// Notes:   Latency slack of the pin synchronisers is folded into each window
`timescale 1ns/10ps
module sac_top_sva
    import sac_pkg::*;
#(
    parameter int PUP_COUNT = PUP_CYCLES // Power-up delay in cycles
)(
    input wire logic                  clock,                   // System clock
    input wire logic                  reset,                   // Power-up reset
    input wire logic                  sel_serial,              // Port select
    input wire logic                  latch_strobe,            // Latch strobe pin
    input wire logic [ATTEN_BITS-1:0] parallel_control_inputs, // Parallel step bits
    input wire logic [ATTEN_BITS-1:0] atten_state,             // Applied code
    input wire logic                  atten_word_top_bit,      // Held top bit
    input wire logic                  power_up_busy            // Delay running
);
    logic [15:0] cnt;
    always_ff @(posedge clock) begin
        if (reset)
            cnt <= 16'h0000;
        else if (cnt != 16'hffff)
            cnt <= cnt + 16'h0001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_reset_state: assert property ($fell(reset) |->
        atten_state == ATTEN_MAX && !atten_word_top_bit) else $error("bad state after reset");
    a_busy_max: assert property (power_up_busy |-> atten_state == ATTEN_MAX)
        else $error("not maximum during delay");
    a_busy_time: assert property (cnt < PUP_COUNT - 1 |-> power_up_busy)
        else $error("delay ended early");
    a_busy_ends: assert property (cnt > PUP_COUNT + 2 |-> !power_up_busy)
        else $error("delay ended late");
    a_serial_hold: assert property ((sel_serial && !latch_strobe && !power_up_busy)[*6]
        |-> $stable(atten_state)) else $error("state moved while shifting");
    a_latch_hold: assert property ((!sel_serial && !latch_strobe && !power_up_busy)[*6]
        |-> $stable(atten_state)) else $error("latched state moved");
    a_direct_follow: assert property ((!sel_serial && latch_strobe && !power_up_busy
        && $stable(parallel_control_inputs))[*6] |-> atten_state == parallel_control_inputs)
        else $error("direct state not following");
    a_par_capture: assert property ($rose(latch_strobe) && !sel_serial && !power_up_busy
        |-> ##[1:5] atten_state == parallel_control_inputs) else $error("no capture");
    a_change_cause: assert property ($changed(atten_state) && $past(power_up_busy, 2) == 1'b0
        |-> $past(latch_strobe, 2) || $past(latch_strobe, 3) || $past(latch_strobe, 4))
        else $error("state changed without strobe");
    c_serial_latch: cover property ($rose(latch_strobe) && sel_serial);
    c_par_latch: cover property ($rose(latch_strobe) && !sel_serial && !power_up_busy);
    c_delay_end: cover property ($fell(power_up_busy));
endmodule

// >>> test/sac_host.sv
// Purpose: Host controller model driving the serial port pins
// Assumes: Called at falling clock edges; serial clock period is 8 clocks
// Notes:   Serial clock rests low between frames
`timescale 1ns/10ps
module sac_host (
    input  wire logic clock,        // System clock
    output logic      serial_clock, // Shift clock pin
    output logic      serial_data,  // Shift data pin
    output logic      latch_strobe  // Latch strobe pin
);
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic shift_bit(input logic b);
        wait_n(2);
        serial_data = b;
        wait_n(2);
        serial_clock = 1'b1;
        wait_n(4);
        serial_clock = 1'b0;
        serial_data = ~b; // Stale bit must not look valid
    endtask
    task automatic latch();
        wait_n(2);
        latch_strobe = 1'b1;
        wait_n(4);
        latch_strobe = 1'b0;
        wait_n(8);
    endtask
    task automatic send16(input logic [15:0] w);
        for (int i = 0; i < 16; i++)
            shift_bit(w[i]);
        latch();
    endtask
endmodule

// >>> test/sac_top_bench.sv
// Purpose: Self-checking bench of the step attenuator control port
// Assumes: Power-up delay shortened to 50 cycles
// Notes:   Straps move to 2 and back to 5 to exercise the address compare
`timescale 1ns/10ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module sac_top_bench;
    import sac_pkg::*;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       sel_serial = 1'b1;
    logic       parallel_float = 1'b0;
    logic [6:0] par = 7'h00;
    logic [2:0] strap = 3'h5;
    logic       serial_clock, serial_data, latch_strobe;
    logic [6:0] atten;
    logic       top_bit, busy;
    int         n_fail = 0;
    int         compares = 0;
    always #10 clock = ~clock;
    sac_host u_host (.clock(clock), .serial_clock(serial_clock), .serial_data(serial_data),
        .latch_strobe(latch_strobe));
    sac_top #(.PUP_COUNT(50)) u_dut (.clock(clock), .reset(reset), .sel_serial(sel_serial),
        .latch_strobe(latch_strobe), .serial_clock(serial_clock), .serial_data(serial_data),
        .parallel_control_inputs(par), .parallel_float(parallel_float),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
        .atten_state(atten), .atten_word_top_bit(top_bit), .power_up_busy(busy));
    task automatic power_up(input logic s, st, input logic [6:0] p, input logic f,
                            input logic [6:0] e);
        @(negedge clock);
        reset = 1'b1;
        sel_serial = s;
        u_host.latch_strobe = st;
        par = p;
        parallel_float = f;
        u_host.wait_n(2);
        reset = 1'b0;
        u_host.wait_n(10);
        `CHECK(busy, 1'b1)
        `CHECK(atten, ATTEN_MAX)
        for (int i = 0; i < 200 && busy !== 1'b0; i++)
            @(negedge clock);
        // Looked at on the first sample after the delay, before direct mode tracks pins
        `CHECK(busy, 1'b0)
        `CHECK(atten, e)
        u_host.wait_n(8);
        parallel_float = 1'b0;
    endtask
    task automatic t_serial();
        u_host.send16({5'h16, 3'h5, 8'h49});
        `CHECK(atten, 7'h49)
        u_host.send16({5'h00, 3'h4, 8'h22});
        `CHECK(atten, 7'h49)
        u_host.shift_bit(1'b1);
        u_host.send16({5'h0b, 3'h5, 8'h8a});
        `CHECK(atten, 7'h0a)
        `CHECK(top_bit, 1'b1)
        u_host.send16({5'h1f, 3'h5, 8'h20});
        `CHECK(top_bit, 1'b0)
        `CHECK(atten, 7'h20)
    endtask
    task automatic t_parallel();
        sel_serial = 1'b0;
        u_host.wait_n(4);
        par = 7'h3c;
        u_host.wait_n(10);
        `CHECK(atten, 7'h20)
        u_host.send16({5'h00, 3'h5, 8'h11});
        `CHECK(atten, 7'h3c)
        u_host.latch_strobe = 1'b1;
        par = 7'h15;
        u_host.wait_n(10);
        `CHECK(atten, 7'h15)
        par = 7'h6a;
        u_host.wait_n(8);
        `CHECK(atten, 7'h6a)
        u_host.latch_strobe = 1'b0;
        u_host.wait_n(4);
        par = 7'h00; // Parallel pins low before serial use
        u_host.wait_n(4);
        sel_serial = 1'b1;
        u_host.wait_n(4);
        u_host.send16({5'h00, 3'h5, 8'h07});
        `CHECK(atten, 7'h07)
    endtask
    task automatic t_strap();
        strap = 3'h2;
        u_host.wait_n(4);
        u_host.send16({5'h00, 3'h5, 8'h13});
        `CHECK(atten, 7'h07)
        u_host.send16({5'h1d, 3'h2, 8'h13});
        `CHECK(atten, 7'h13)
        strap = 3'h5;
    endtask
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        power_up(1'b0, 1'b1, 7'h2a, 1'b0, 7'h2a);
        power_up(1'b0, 1'b1, 7'h33, 1'b1, ATTEN_MIN);
        power_up(1'b0, 1'b0, 7'h11, 1'b0, ATTEN_MAX);
        power_up(1'b1, 1'b0, 7'h00, 1'b0, ATTEN_MAX);
        t_serial();
        t_parallel();
        t_strap();
        print_verdict();
    end
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
endmodule
bind sac_top sac_top_sva #(.PUP_COUNT(PUP_COUNT)) u_sva (.clock(clock), .reset(reset),
    .sel_serial(sel_serial), .latch_strobe(latch_strobe),
    .parallel_control_inputs(parallel_control_inputs), .atten_state(atten_state),
    .atten_word_top_bit(atten_word_top_bit), .power_up_busy(power_up_busy));
